// [logic/video_afe_input_gain_offset_regs.v]
// configuration register bank of a triple video digitizer front end
// assumes an avalon-mm master on core_clk; sync and hold pins are asynchronous
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "afe_regs_map.vh"

// Overview of operation
// - AC coupling: positive input clamps only in clamp time, negative always clamped.
// - DC coupling: inputs to pads, no clamp connection, analog clamp held off.
// - RGB: all clamps 300mV, half-scale shift everywhere, black target 0x00.
// - YUV: red/blue 600mV clamp, target 0x80; green 300mV, shifted, target 0x00.
// - Sync-type bit: separate syncs when clear, composite sync when set.
// - Composite source: sync-on-green or hsync; separate mode always passes hsync.
// - Hold-clamp bit clear stops positive and analog clamping and black_comp_run_ff during PLL hold; offset_path keeps adding its digital offset.
// - Each 8-bit gain code drives its channel gain stage, 0.5 + code/170.
// - With compensation on, one offset step shifts output by one LSB.
// - Offset code is excess-128: 0x00=-128, 0x80=0, 0xFF=+127.
// - With compensation off, offset code feeds upper 8 bits of 10-bit DAC.
// - Range bit selects +-1/2 full scale when clear, +-1/4 when set.
// - Offset setup bits 3:2, 5:4, 7:6 give red, green, blue DAC low bits.
module video_afe_input_gain_offset_regs #(
	parameter DW = 8
) (
	input  wire          core_clk,
	input  wire          rst,
	input  wire [5:0]    avs_address,
	input  wire          avs_read,
	input  wire          avs_write,
	input  wire [31:0]   avs_writedata,
	input  wire [3:0]    avs_byteenable,
	output reg  [31:0]   avs_readdata,
	output wire          avs_waitrequest,
	input  wire          hsync_pin,
	input  wire          sog_pin,
	input  wire          clamp_window,
	input  wire          pll_hold,
	input  wire          auto_black_en,
	input  wire [DW-1:0] red_adc_in,
	input  wire [DW-1:0] green_adc_in,
	input  wire [DW-1:0] blue_adc_in,
	output reg           input_set_b_sel_ff,
	output reg           pos_to_clamp_ff,
	output reg           neg_to_clamp_ff,
	output reg           analog_clamp_ff,
	output reg  [2:0]    clamp_level_ff,
	output reg  [2:0]    half_shift_ff,
	output reg  [7:0]    red_target_ff,
	output reg  [7:0]    green_target_ff,
	output reg  [7:0]    blue_target_ff,
	output reg           composite_mode_ff,
	output reg           sync_sel_ff,
	output reg           black_comp_run_ff,
	output reg  [7:0]    red_gain_ff,
	output reg  [7:0]    green_gain_ff,
	output reg  [7:0]    blue_gain_ff,
	output reg           dac_quarter_range_ff,
	output wire [DW-1:0] red_adc_out_ff,
	output wire [DW-1:0] green_adc_out_ff,
	output wire [DW-1:0] blue_adc_out_ff,
	output wire [9:0]    red_offset_dac_ff,
	output wire [9:0]    green_offset_dac_ff,
	output wire [9:0]    blue_offset_dac_ff
);

	localparam ST_IDLE = 1'b0;
	localparam ST_DONE = 1'b1;

	reg        state_ff;
	reg        nxt_state;
	reg  [7:0] input_configuration_ff;
	reg  [7:0] red_offset_code_ff;
	reg  [7:0] green_offset_code_ff;
	reg  [7:0] blue_offset_code_ff;
	reg  [7:0] offset_dac_setup_ff;
	reg  [7:0] rd_byte;
	reg        rd_hit;
	wire [3:0] idx;
	wire       req;
	wire       wr_go;
	wire       aligned;
	wire       hsync_s;
	wire       sog_s;
	wire       clamp_s;
	wire       hold_s;
	wire       dc_couple;
	wire       yuv;
	wire       composite;
	wire       hold_ok;

	assign idx   = avs_address[5:2];
	assign req   = avs_read | avs_write;
	// one wait cycle: request answered on the second edge it is held
	assign avs_waitrequest = req & (state_ff == ST_IDLE);
	assign wr_go = avs_write & (state_ff == ST_DONE) & avs_byteenable[0];
	assign aligned = (avs_address[1:0] == 2'b00);

	always @*
	begin
		case (state_ff)
			ST_IDLE: nxt_state = req ? ST_DONE : ST_IDLE;
			ST_DONE: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// reserved bits are stored as written; host keeps them zero
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff               <= ST_IDLE;
			input_configuration_ff <= `RST_INPUT_CFG;
			red_gain_ff            <= `RST_GAIN;
			green_gain_ff          <= `RST_GAIN;
			blue_gain_ff           <= `RST_GAIN;
			red_offset_code_ff     <= `RST_OFFSET;
			green_offset_code_ff   <= `RST_OFFSET;
			blue_offset_code_ff    <= `RST_OFFSET;
			offset_dac_setup_ff    <= `RST_OFFSET_DAC;
		end
		else
		begin
			state_ff <= nxt_state;
			if (wr_go && aligned)
			begin
				case (idx)
					`IDX_INPUT_CFG:    input_configuration_ff <= avs_writedata[7:0];
					`IDX_RED_GAIN:     red_gain_ff            <= avs_writedata[7:0];
					`IDX_GREEN_GAIN:   green_gain_ff          <= avs_writedata[7:0];
					`IDX_BLUE_GAIN:    blue_gain_ff           <= avs_writedata[7:0];
					`IDX_RED_OFFSET:   red_offset_code_ff     <= avs_writedata[7:0];
					`IDX_GREEN_OFFSET: green_offset_code_ff   <= avs_writedata[7:0];
					`IDX_BLUE_OFFSET:  blue_offset_code_ff    <= avs_writedata[7:0];
					`IDX_OFFSET_DAC:   offset_dac_setup_ff    <= avs_writedata[7:0];
					default:           ;
				endcase
			end
		end
	end

	always @*
	begin
		rd_hit = 1'b1;
		case (idx)
			`IDX_INPUT_CFG:    rd_byte = input_configuration_ff;
			`IDX_RED_GAIN:     rd_byte = red_gain_ff;
			`IDX_GREEN_GAIN:   rd_byte = green_gain_ff;
			`IDX_BLUE_GAIN:    rd_byte = blue_gain_ff;
			`IDX_RED_OFFSET:   rd_byte = red_offset_code_ff;
			`IDX_GREEN_OFFSET: rd_byte = green_offset_code_ff;
			`IDX_BLUE_OFFSET:  rd_byte = blue_offset_code_ff;
			`IDX_OFFSET_DAC:   rd_byte = offset_dac_setup_ff;
			default:
			begin
				rd_byte = 8'h00;
				rd_hit  = 1'b0;
			end
		endcase
	end

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			avs_readdata <= `RDATA_UNMAPPED;
		// loaded on the first edge of the read, while waitrequest is high, so it stands while waitrequest is low
		else if (avs_read && state_ff == ST_IDLE)
			avs_readdata <= (rd_hit && aligned) ?
				{24'h000000, rd_byte} : `RDATA_UNMAPPED;
	end

	// all four pins are asynchronous to core_clk
	sync_in u_sync_hs (
		.core_clk (core_clk),
		.rst      (rst),
		.d        (hsync_pin),
		.q_ff     (hsync_s)
	);

	sync_in u_sync_sog (
		.core_clk (core_clk),
		.rst      (rst),
		.d        (sog_pin),
		.q_ff     (sog_s)
	);

	sync_in u_sync_clamp (
		.core_clk (core_clk),
		.rst      (rst),
		.d        (clamp_window),
		.q_ff     (clamp_s)
	);

	sync_in u_sync_hold (
		.core_clk (core_clk),
		.rst      (rst),
		.d        (pll_hold),
		.q_ff     (hold_s)
	);

	assign dc_couple = input_configuration_ff[`BIT_DC_COUPLE];
	assign yuv       = input_configuration_ff[`BIT_YUV];
	assign composite = input_configuration_ff[`BIT_COMPOSITE];
	assign hold_ok   = ~hold_s | input_configuration_ff[`BIT_HOLD_CLAMP];

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			input_set_b_sel_ff   <= 1'b0;
			pos_to_clamp_ff      <= 1'b0;
			neg_to_clamp_ff      <= 1'b0;
			analog_clamp_ff      <= 1'b0;
			clamp_level_ff       <= 3'b000;
			half_shift_ff        <= 3'b000;
			red_target_ff        <= `TARGET_ZERO;
			green_target_ff      <= `TARGET_ZERO;
			blue_target_ff       <= `TARGET_ZERO;
		end
		else
		begin
			input_set_b_sel_ff <= input_configuration_ff[`BIT_INPUT_SEL];
			// dc mode never touches the clamp dacs
			analog_clamp_ff <= ~dc_couple & clamp_s & hold_ok;
			pos_to_clamp_ff <= ~dc_couple & clamp_s & hold_ok;
			neg_to_clamp_ff <= ~dc_couple;
			// clamp order {blue, green, red}
			clamp_level_ff  <= yuv ? {`CLAMP_600MV, `CLAMP_300MV, `CLAMP_600MV}
				: {`CLAMP_300MV, `CLAMP_300MV, `CLAMP_300MV};
			half_shift_ff   <= yuv ? `HALF_SHIFT_YUV : `HALF_SHIFT_RGB;
			red_target_ff   <= yuv ? `TARGET_MID : `TARGET_ZERO;
			green_target_ff <= `TARGET_ZERO;
			blue_target_ff  <= yuv ? `TARGET_MID : `TARGET_ZERO;
		end
	end

	// sync path kept apart from the clamp controls so each can be retimed alone
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			composite_mode_ff <= 1'b0;
			sync_sel_ff       <= 1'b0;
		end
		else
		begin
			composite_mode_ff <= composite;
			// separate mode forces hsync whatever the source bit says
			sync_sel_ff <= (composite && !input_configuration_ff[`BIT_CSYNC_HS])
				? sog_s : hsync_s;
		end
	end

	// compensation enable is on core_clk already, no synchroniser
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			black_comp_run_ff    <= 1'b0;
			dac_quarter_range_ff <= 1'b0;
		end
		else
		begin
			black_comp_run_ff    <= auto_black_en & hold_ok;
			dac_quarter_range_ff <= offset_dac_setup_ff[`BIT_DAC_RANGE];
		end
	end

	offset_path #(.DW(DW)) u_red (
		.core_clk      (core_clk),
		.rst           (rst),
		.offset_code   (red_offset_code_ff),
		.dac_low_bits  (offset_dac_setup_ff[`LSB_RED_LO+1:`LSB_RED_LO]),
		.auto_black_en (auto_black_en),
		.adc_in        (red_adc_in),
		.adc_out_ff    (red_adc_out_ff),
		.offset_dac_ff (red_offset_dac_ff)
	);

	offset_path #(.DW(DW)) u_green (
		.core_clk      (core_clk),
		.rst           (rst),
		.offset_code   (green_offset_code_ff),
		.dac_low_bits  (offset_dac_setup_ff[`LSB_GREEN_LO+1:`LSB_GREEN_LO]),
		.auto_black_en (auto_black_en),
		.adc_in        (green_adc_in),
		.adc_out_ff    (green_adc_out_ff),
		.offset_dac_ff (green_offset_dac_ff)
	);

	offset_path #(.DW(DW)) u_blue (
		.core_clk      (core_clk),
		.rst           (rst),
		.offset_code   (blue_offset_code_ff),
		.dac_low_bits  (offset_dac_setup_ff[`LSB_BLUE_LO+1:`LSB_BLUE_LO]),
		.auto_black_en (auto_black_en),
		.adc_in        (blue_adc_in),
		.adc_out_ff    (blue_adc_out_ff),
		.offset_dac_ff (blue_offset_dac_ff)
	);

endmodule // video_afe_input_gain_offset_regs
`default_nettype wire

// [logic/afe_regs_map.vh]
// register map, field positions and reset values for the afe config bank
// included by the register bank and offset_path design files of the block; sync_in does not include it
`ifndef AFE_REGS_MAP_VH
`define AFE_REGS_MAP_VH

`define IDX_INPUT_CFG     4'h5
`define IDX_RED_GAIN      4'h6
`define IDX_GREEN_GAIN    4'h7
`define IDX_BLUE_GAIN     4'h8
`define IDX_RED_OFFSET    4'h9
`define IDX_GREEN_OFFSET  4'hA
`define IDX_BLUE_OFFSET   4'hB
`define IDX_OFFSET_DAC    4'hC

`define RST_INPUT_CFG     8'h00
`define RST_GAIN          8'h55
`define RST_OFFSET        8'h80
`define RST_OFFSET_DAC    8'h00

`define BIT_INPUT_SEL     0
`define BIT_DC_COUPLE     1
`define BIT_YUV           2
`define BIT_COMPOSITE     3
`define BIT_CSYNC_HS      4
`define BIT_HOLD_CLAMP    5
`define BIT_DAC_RANGE     0
`define LSB_RED_LO        2
`define LSB_GREEN_LO      4
`define LSB_BLUE_LO       6

`define OFFSET_BIAS       8'h80
`define TARGET_ZERO       8'h00
`define TARGET_MID        8'h80
// half-scale shift masks, order {blue, green, red}
`define HALF_SHIFT_RGB    3'h7
`define HALF_SHIFT_YUV    3'h2
// clamp dac level codes: 0 = 300 mV, 1 = 600 mV
`define CLAMP_300MV       1'b0
`define CLAMP_600MV       1'b1
`define RDATA_UNMAPPED    32'h00000000

`endif

// [logic/offset_path.v]
// one channel of offset handling: digital excess-128 offset or 10-bit dac code
// assumes offset code and low bits come from the register bank, same clock
`timescale 1ns/100ps
`default_nettype none
`include "afe_regs_map.vh"

module offset_path #(
	parameter DW = 8
) (
	input  wire          core_clk,
	input  wire          rst,
	input  wire [7:0]    offset_code,
	input  wire [1:0]    dac_low_bits,
	input  wire          auto_black_en,
	input  wire [DW-1:0] adc_in,
	output reg  [DW-1:0] adc_out_ff,
	output reg  [9:0]    offset_dac_ff
);

	wire signed [9:0] signed_offset;
	wire signed [9:0] sum;
	reg         [DW-1:0] nxt_adc_out;

	// excess-128 decode
	assign signed_offset = {{2{~offset_code[7]}}, ~offset_code[7], offset_code[6:0]};
	assign sum = $signed({2'b00, adc_in}) + signed_offset;

	// saturate so a large offset never wraps the pixel value
	always @*
	begin
		if (!auto_black_en)
			nxt_adc_out = adc_in;
		else if (sum < 0)
			nxt_adc_out = {DW{1'b0}};
		else if (sum > 10'sd255)
			nxt_adc_out = {DW{1'b1}};
		else
			nxt_adc_out = sum[DW-1:0];
	end

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			adc_out_ff    <= {DW{1'b0}};
			offset_dac_ff <= {`RST_OFFSET, 2'b00};
		end
		else
		begin
			adc_out_ff <= nxt_adc_out;
			// dac keeps its last manual value while offset is digital
			if (!auto_black_en)
				offset_dac_ff <= {offset_code, dac_low_bits};
		end
	end

endmodule // offset_path
`default_nettype wire

// [logic/sync_in.v]
// two-flop synchroniser for a level from a pin
// assumes the level is slow compared to core_clk
`timescale 1ns/100ps
`default_nettype none

module sync_in (
	input  wire core_clk,
	input  wire rst,
	input  wire d,
	output reg  q_ff
);

	reg meta_ff;

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_ff <= 1'b0;
			q_ff    <= 1'b0;
		end
		else
		begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

endmodule // sync_in
`default_nettype wire

// [test/afe_regs_monitor.sv]
// assertions on the outputs of the afe config bank
// bound into the top module, sees only its ports
`timescale 1ns/100ps
`default_nettype none
module afe_regs_monitor #(
	parameter DW = 8
) (
	input wire logic          core_clk,
	input wire logic          rst,
	input wire logic [5:0]    avs_address,
	input wire logic          avs_write,
	input wire logic [31:0]   avs_writedata,
	input wire logic [3:0]    avs_byteenable,
	input wire logic          avs_waitrequest,
	input wire logic          hsync_pin,
	input wire logic          pll_hold,
	input wire logic          auto_black_en,
	input wire logic [DW-1:0] red_adc_in,
	input wire logic          pos_to_clamp_ff,
	input wire logic          neg_to_clamp_ff,
	input wire logic          analog_clamp_ff,
	input wire logic [2:0]    clamp_level_ff,
	input wire logic [7:0]    red_target_ff,
	input wire logic [7:0]    green_target_ff,
	input wire logic [7:0]    blue_target_ff,
	input wire logic          composite_mode_ff,
	input wire logic          sync_sel_ff,
	input wire logic          black_comp_run_ff,
	input wire logic [7:0]    red_gain_ff,
	input wire logic          dac_quarter_range_ff,
	input wire logic [DW-1:0] red_adc_out_ff,
	input wire logic [9:0]    red_offset_dac_ff
);
	logic [7:0] wd_ff;
	wire logic  wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	// last accepted write data, so the delayed compare sees the right byte
	always @(posedge core_clk or posedge rst)
		if (rst)
			wd_ff <= 8'h00;
		else if (wr_ok)
			wd_ff <= avs_writedata[7:0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_ac_pos_clamp: assert property (pos_to_clamp_ff |-> neg_to_clamp_ff)
		else $error("positive input clamped outside ac mode");
	a_dc_clamp_off: assert property (analog_clamp_ff |-> neg_to_clamp_ff)
		else $error("analog clamp active in dc mode");
	a_green_clamp: assert property (!clamp_level_ff[1] && green_target_ff == 8'h00)
		else $error("green clamp or target wrong");
	a_red_target: assert property (red_target_ff == {clamp_level_ff[0], 7'h00})
		else $error("red target does not follow colour space");
	a_blue_target: assert property (blue_target_ff == {clamp_level_ff[2], 7'h00})
		else $error("blue target does not follow colour space");
	a_sep_hsync: assert property ((!composite_mode_ff && $stable(hsync_pin))[*5]
		|-> sync_sel_ff == hsync_pin) else $error("separate mode not passing hsync");
	a_hold_comp_run: assert property ((!pll_hold)[*4] ##0 $past(auto_black_en)
		|-> black_comp_run_ff) else $error("compensation stopped without hold");
	a_gain_write: assert property (wr_ok && avs_address == 6'h18
		|-> ##[1:2] red_gain_ff == wd_ff) else $error("red gain not updated");
	a_range_write: assert property (wr_ok && avs_address == 6'h30
		|-> ##[1:2] dac_quarter_range_ff == wd_ff[0]) else $error("range bit not updated");
	a_analog_pass: assert property (!$past(rst) && !$past(auto_black_en)
		|-> red_adc_out_ff == $past(red_adc_in)) else $error("analog mode altered data");
	a_dac_holds: assert property (!$past(rst) && $past(auto_black_en)
		&& $past(auto_black_en, 2) |-> $stable(red_offset_dac_ff))
		else $error("offset dac moved in digital mode");
endmodule // afe_regs_monitor
bind video_afe_input_gain_offset_regs afe_regs_monitor #(.DW(DW)) afe_regs_monitor_inst (.*);
`default_nettype wire

// [test/video_afe_input_gain_offset_regs_test.sv]
// self-checking bench for the afe config bank
// drives the avalon-mm port and all pins itself, no far-side model
`timescale 1ns/100ps
`default_nettype none
module video_afe_input_gain_offset_regs_test;
	logic        core_clk, rst, avs_read, avs_write, hsync_pin, sog_pin;
	logic        clamp_window, pll_hold, auto_black_en, avs_waitrequest;
	logic        input_set_b_sel_ff, pos_to_clamp_ff, neg_to_clamp_ff, analog_clamp_ff;
	logic        composite_mode_ff, sync_sel_ff, black_comp_run_ff, dac_quarter_range_ff;
	logic [2:0]  clamp_level_ff, half_shift_ff;
	logic [3:0]  avs_byteenable;
	logic [5:0]  avs_address;
	logic [7:0]  red_adc_in, green_adc_in, blue_adc_in, q, red_gain_ff, green_gain_ff;
	logic [7:0]  red_target_ff, green_target_ff, blue_target_ff, blue_gain_ff;
	logic [7:0]  red_adc_out_ff, green_adc_out_ff, blue_adc_out_ff;
	logic [9:0]  red_offset_dac_ff, green_offset_dac_ff, blue_offset_dac_ff;
	logic [31:0] avs_writedata, avs_readdata;
	int          errors, tests_run, i;
	video_afe_input_gain_offset_regs video_afe_input_gain_offset_regs_inst (.*);
	always #20 core_clk = ~core_clk;
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
	begin
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one request held until waitrequest is seen low at a rising edge
	task xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
	begin
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 20)
		begin
			errors++;
			$display("BAD waitrequest expected 0 seen stuck");
			tally_and_finish;
		end
	end
	endtask
	task t_reset;
	begin
		for (i = 0; i < 8; i++)
		begin
			xfer(0, 6'(6'h14 + 4 * i), 8'h00);
			chk("reset value", (i == 0 || i == 7) ? 8'h00 : (i < 4) ? 8'h55 : 8'h80, q);
		end
		chk("gain out", 8'h55, blue_gain_ff);
		chk("dac out", 10'h200, green_offset_dac_ff);
		$display("end of reset test");
	end
	endtask
	task t_regs;
	begin
		for (i = 0; i < 8; i++)
			xfer(1, 6'(6'h14 + 4 * i), 8'(8'h11 * (i + 1)));
		for (i = 0; i < 8; i++)
		begin
			xfer(0, 6'(6'h14 + 4 * i), 8'h00);
			chk("readback", 8'(8'h11 * (i + 1)), q);
		end
		chk("gains", 24'h223344, {red_gain_ff, green_gain_ff, blue_gain_ff});
		chk("input set b", 1'b1, input_set_b_sel_ff);
		xfer(1, 6'h34, 8'h5A);
		xfer(0, 6'h34, 8'h00);
		chk("unmapped", 8'h00, q);
		xfer(0, 6'h19, 8'h00);
		chk("misaligned", 8'h00, q);
		avs_byteenable <= 4'h0;
		xfer(1, 6'h18, 8'hEE);
		avs_byteenable <= 4'hF;
		xfer(0, 6'h18, 8'h00);
		chk("no byte lane", 8'h22, q);
		$display("end of register test");
	end
	endtask
	task t_coupling;
	begin
		clamp_window <= 1'b1;
		xfer(1, 6'h14, 8'h00);
		cyc(5);
		chk("ac clamp", 3'b111, {pos_to_clamp_ff, neg_to_clamp_ff, analog_clamp_ff});
		clamp_window <= 1'b0;
		cyc(5);
		chk("ac outside", 3'b010, {pos_to_clamp_ff, neg_to_clamp_ff, analog_clamp_ff});
		clamp_window <= 1'b1;
		xfer(1, 6'h14, 8'h02);
		cyc(5);
		chk("dc mode", 3'b000, {pos_to_clamp_ff, neg_to_clamp_ff, analog_clamp_ff});
		$display("end of coupling test");
	end
	endtask
	task t_colour;
	begin
		xfer(1, 6'h14, 8'h00);
		cyc(2);
		chk("rgb", 30'h07000000, {clamp_level_ff, half_shift_ff, red_target_ff,
			green_target_ff, blue_target_ff});
		xfer(1, 6'h14, 8'h04);
		cyc(2);
		chk("yuv", 30'h2A800080, {clamp_level_ff, half_shift_ff, red_target_ff,
			green_target_ff, blue_target_ff});
		$display("end of colour test");
	end
	endtask
	task t_sync;
	begin
		hsync_pin <= 1'b1;
		xfer(1, 6'h14, 8'h00);
		cyc(5);
		chk("separate", 2'b01, {composite_mode_ff, sync_sel_ff});
		xfer(1, 6'h14, 8'h08);
		cyc(5);
		chk("composite sog", 2'b10, {composite_mode_ff, sync_sel_ff});
		sog_pin <= 1'b1;
		cyc(5);
		chk("sog high", 1'b1, sync_sel_ff);
		hsync_pin <= 1'b0;
		xfer(1, 6'h14, 8'h18);
		cyc(5);
		chk("composite hsync", 1'b0, sync_sel_ff);
		$display("end of sync test");
	end
	endtask
	task t_hold;
	begin
		auto_black_en <= 1'b1;
		pll_hold <= 1'b1;
		xfer(1, 6'h14, 8'h00);
		cyc(5);
		chk("hold stops", 2'b00, {black_comp_run_ff, pos_to_clamp_ff});
		xfer(1, 6'h14, 8'h20);
		cyc(5);
		chk("hold continues", 2'b11, {black_comp_run_ff, pos_to_clamp_ff});
		pll_hold <= 1'b0;
		$display("end of hold test");
	end
	endtask
	task t_offset;
	begin
		red_adc_in <= 8'h40;
		green_adc_in <= 8'h10;
		blue_adc_in <= 8'h40;
		xfer(1, 6'h24, 8'h81);
		xfer(1, 6'h28, 8'hFF);
		xfer(1, 6'h2C, 8'h00);
		cyc(3);
		chk("red step", 8'h41, red_adc_out_ff);
		chk("green max", 8'h8F, green_adc_out_ff);
		chk("blue min", 8'h00, blue_adc_out_ff);
		auto_black_en <= 1'b0;
		xfer(1, 6'h30, 8'hE5);
		cyc(3);
		chk("dac", 30'h205FF803, {red_offset_dac_ff, green_offset_dac_ff,
			blue_offset_dac_ff});
		chk("quarter", 1'b1, dac_quarter_range_ff);
		chk("pass", 8'h40, red_adc_out_ff);
		xfer(1, 6'h30, 8'h00);
		cyc(2);
		chk("half", 1'b0, dac_quarter_range_ff);
		$display("end of offset test");
	end
	endtask
	initial
	begin
		core_clk = 1'b0;
		rst = 1'b1;
		{avs_read, avs_write, hsync_pin, sog_pin, clamp_window, pll_hold} = 6'h00;
		{auto_black_en, avs_address, avs_writedata} = 39'h0;
		{red_adc_in, green_adc_in, blue_adc_in} = 24'h0;
		avs_byteenable = 4'hF;
		errors = 0;
		tests_run = 0;
		cyc(3);
		rst <= 1'b0;
		t_reset;
		t_regs;
		t_coupling;
		t_colour;
		t_sync;
		t_hold;
		t_offset;
		tally_and_finish;
	end
endmodule // video_afe_input_gain_offset_regs_test
`default_nettype wire
